// ### hw/cfr_cfg.svh
// address map, field positions and timing for the card function registers
`ifndef CFR_CFG_SVH
`define CFR_CFG_SVH
`define CFR_F0_STAT 13'h1022
`define CFR_F0_PIN 13'h1024
`define CFR_F0_RING 13'h1028
`define CFR_F0_BASE_LO 13'h102A
`define CFR_F0_BASE_HI 13'h102C
`define CFR_F0_MASK 13'h1032
`define CFR_F1_STAT 13'h1042
`define CFR_F1_PIN 13'h1044
`define CFR_F1_RING 13'h1048
`define CFR_F1_BASE_LO 13'h104A
`define CFR_F1_BASE_HI 13'h104C
`define CFR_F1_MASK 13'h1052
`define CFR_ST_CHANGED 7
`define CFR_ST_GATE 6
`define CFR_ST_EIGHT 5
`define CFR_ST_AUDIO 3
`define CFR_ST_PDOWN 2
`define CFR_ST_INTR 1
`define CFR_ST_RETRIG 0
`define CFR_PIN_RDYCHG 5
`define CFR_PIN_RDYLIVE 1
`define CFR_PIN_CLR_VAL 8'h02
`define CFR_RING_EVT 4
`define CFR_RING_EN 0
`define CFR_RING_CLR_VAL 8'h10
`define CFR_RST_BYTE 8'h00
`define CFR_PULSE_CYC 16
`define CFR_LOW_MIN_NS 500
`define CFR_CLK_NS 5
`define CFR_LOW_CYC ((`CFR_LOW_MIN_NS + `CFR_CLK_NS - 1) / `CFR_CLK_NS)
`endif

// ### hw/cfr_pkg.sv
// types shared by the card function register bank
package cfr_pkg;
  typedef enum logic [1:0] {
    CFR_IDLE = 2'b00,
    CFR_PULSE = 2'b01,
    CFR_GAP = 2'b10
  } cfr_irq_e;
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cfr_bus_s;
  typedef struct packed {
    logic irq;
    logic ready;
    logic ring_n;
    logic configured;
    logic irq_enable;
  } cfr_func_s;
endpackage

// ### hw/cfr_regs.sv
// function status, pin mirror, ring event and io window registers
`include "cfr_cfg.svh"

// Behaviour
// - changed bit set whenever any pin-register change bit is one.
// - status-change output when changed and gate set, in io mode.
// - speaker out follows speaker in when an audio bit set and configured.
// - power-down drops power control and floats function signals.
// - interrupt-pending bit follows the function irq input.
// - retrigger mode zero ignores writes to interrupt-pending bit.
// - retrigger mode one, writing zero re-evaluates inputs, new pulse.
// - host irq driven by OR of enabled function interrupts.
// - pulse mode retrigger is high-low-high, low at least 0.5 us.
// - level mode retrigger is low-high-low then stays low.
// - retrigger mode and pending writes are shared by both functions.
// - ready-changed set on ready toggle, cleared by writing 02h.
// - ready live bit mirrors ready pin; other bits unimplemented.
// - ring event latched when enabled, cleared by writing 10h.
// - latched ring event with enable forces the changed bit.
// - base is 13 bits: low byte 7-0, high byte 12-8.
// - at most 13 host address lines decoded, 8k space.
// - mask one bits excluded from window compare.
// - window naturally aligned; masked base bits ignored.
// - level select one gives level mode, zero pulse mode.
// - pulse-mode interrupt lasts 100 master clocks, the larger of 16 and 0.5 us.
// - irq counts only while function irq enable is one.
module cfr_regs #(
  parameter int NFUNC = 2,
  parameter int AW = 13
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire cfr_pkg::cfr_bus_s bus_i,
  input wire logic io_mode_i,
  input wire logic level_irq_select_i,
  input wire cfr_pkg::cfr_func_s [1:0] func_i,
  input wire logic speaker_in_i,
  input wire logic [12:0] io_addr_i,
  output logic [7:0] rdata_o,
  output logic status_change_n_o,
  output logic host_irq_n_o,
  output logic speaker_out_n_o,
  output logic [1:0] function_power_ctl_o,
  output logic [1:0] function_oe_n_o,
  output logic [1:0] func_select_o
);
  import cfr_pkg::*;

  // the decode and register map are fixed to this shape
  if (NFUNC != 2 || AW != 13) begin : g_bad_params
    $error("cfr_regs serves two functions and 13 address lines only");
  end

  localparam int LOW_CYC = `CFR_LOW_CYC;
  localparam int HOLD_CYC = (LOW_CYC > `CFR_PULSE_CYC) ? LOW_CYC :
                            `CFR_PULSE_CYC;

  logic [1:0] gate_r, eight_r, audio_r, pdown_r;
  logic retrig_r;
  logic [1:0] rdychg_r, ready_q_r, ring_evt_r, ring_en_r;
  logic [1:0][12:0] base_r;
  logic [1:0][7:0] mask_r;
  cfr_irq_e irq_st_r;
  logic [7:0] cnt_r;
  logic [1:0] intr_live;
  logic [1:0] changed;
  logic any_req;
  logic retrig_kick;

  function automatic logic wr_at(input logic [12:0] a);
    wr_at = bus_i.wr && (bus_i.addr == a);
  endfunction

  function automatic logic [12:0] off(input int f, input logic [12:0] a0,
                                      input logic [12:0] a1);
    off = (f == 0) ? a0 : a1;
  endfunction

  always_comb begin
    retrig_kick = 1'b0;
    for (int f = 0; f < 2; f++) begin
      if (wr_at(off(f, `CFR_F0_STAT, `CFR_F1_STAT)) &&
          !bus_i.wdata[`CFR_ST_INTR] && retrig_r) begin
        retrig_kick = 1'b1;
      end
    end
  end

  generate
    for (genvar g = 0; g < 2; g++) begin : g_func
      localparam logic [12:0] A_ST = (g == 0) ? `CFR_F0_STAT : `CFR_F1_STAT;
      localparam logic [12:0] A_PIN = (g == 0) ? `CFR_F0_PIN : `CFR_F1_PIN;
      localparam logic [12:0] A_RI = (g == 0) ? `CFR_F0_RING : `CFR_F1_RING;
      localparam logic [12:0] A_BL =
        (g == 0) ? `CFR_F0_BASE_LO : `CFR_F1_BASE_LO;
      localparam logic [12:0] A_BH =
        (g == 0) ? `CFR_F0_BASE_HI : `CFR_F1_BASE_HI;
      localparam logic [12:0] A_MK = (g == 0) ? `CFR_F0_MASK : `CFR_F1_MASK;

      // pending bit is live; host writes never store it
      assign intr_live[g] = func_i[g].irq;
      assign changed[g] = rdychg_r[g] |
                          (ring_evt_r[g] & ring_en_r[g]);

      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          gate_r[g] <= 1'b0;
          eight_r[g] <= 1'b0;
          audio_r[g] <= 1'b0;
          pdown_r[g] <= 1'b0;
        end else if (ce_i && wr_at(A_ST)) begin
          gate_r[g] <= bus_i.wdata[`CFR_ST_GATE];
          eight_r[g] <= bus_i.wdata[`CFR_ST_EIGHT];
          audio_r[g] <= bus_i.wdata[`CFR_ST_AUDIO];
          pdown_r[g] <= bus_i.wdata[`CFR_ST_PDOWN];
        end
      end

      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          ready_q_r[g] <= 1'b0;
          rdychg_r[g] <= 1'b0;
        end else if (ce_i) begin
          ready_q_r[g] <= func_i[g].ready;
          // a toggle in the clearing cycle keeps the flag set
          if (ready_q_r[g] != func_i[g].ready) begin
            rdychg_r[g] <= 1'b1;
          end else if (wr_at(A_PIN) && bus_i.wdata == `CFR_PIN_CLR_VAL) begin
            rdychg_r[g] <= 1'b0;
          end
        end
      end

      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          ring_en_r[g] <= 1'b0;
          ring_evt_r[g] <= 1'b0;
        end else if (ce_i) begin
          if (wr_at(A_RI)) begin
            ring_en_r[g] <= bus_i.wdata[`CFR_RING_EN];
          end
          if (!func_i[g].ring_n && ring_en_r[g]) begin
            ring_evt_r[g] <= 1'b1;
          end else if (wr_at(A_RI) && bus_i.wdata == `CFR_RING_CLR_VAL) begin
            ring_evt_r[g] <= 1'b0;
          end
        end
      end

      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          base_r[g] <= 13'h0000;
          mask_r[g] <= `CFR_RST_BYTE;
        end else if (ce_i) begin
          if (wr_at(A_BL)) begin
            base_r[g][7:0] <= bus_i.wdata;
          end
          if (wr_at(A_BH)) begin
            base_r[g][12:8] <= bus_i.wdata[4:0];
          end
          if (wr_at(A_MK)) begin
            mask_r[g] <= bus_i.wdata;
          end
        end
      end

      // compare only unmasked lines, so the window aligns to its size
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          func_select_o[g] <= 1'b0;
        end else if (ce_i) begin
          func_select_o[g] <= !pdown_r[g] &&
            func_i[g].configured &&
            (((io_addr_i ^ base_r[g]) &
              ~{5'h00, mask_r[g]}) == 13'h0000);
        end
      end

      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          function_power_ctl_o[g] <= 1'b0;
          function_oe_n_o[g] <= 1'b1;
        end else if (ce_i) begin
          function_power_ctl_o[g] <= !pdown_r[g];
          function_oe_n_o[g] <= pdown_r[g];
        end
      end
    end
  endgenerate

  // retrigger mode is one shared bit for both status registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      retrig_r <= 1'b0;
    end else if (ce_i && (wr_at(`CFR_F0_STAT) || wr_at(`CFR_F1_STAT))) begin
      retrig_r <= bus_i.wdata[`CFR_ST_RETRIG];
    end
  end

  always_comb begin
    any_req = 1'b0;
    for (int f = 0; f < 2; f++) begin
      any_req = any_req |
                (intr_live[f] & func_i[f].irq_enable);
    end
  end

  // host irq sequencer; pulse holds 100 clocks, never under 0.5 us
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_st_r <= CFR_IDLE;
      cnt_r <= 8'h00;
      host_irq_n_o <= 1'b1;
    end else if (ce_i) begin
      case (irq_st_r)
        CFR_IDLE: begin
          if (level_irq_select_i) begin
            host_irq_n_o <= !any_req;
            if (retrig_kick && any_req) begin
              host_irq_n_o <= 1'b1;
              cnt_r <= 8'(HOLD_CYC - 1);
              irq_st_r <= CFR_GAP;
            end
          end else begin
            host_irq_n_o <= 1'b1;
            if (any_req) begin
              host_irq_n_o <= 1'b0;
              cnt_r <= 8'(HOLD_CYC - 1);
              irq_st_r <= CFR_PULSE;
            end
          end
        end
        CFR_PULSE: begin
          if (cnt_r == 8'h00) begin
            host_irq_n_o <= 1'b1;
            irq_st_r <= CFR_GAP;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        CFR_GAP: begin
          // pulse mode waits for release or a retrigger
          if (level_irq_select_i) begin
            if (cnt_r == 8'h00) begin
              host_irq_n_o <= !any_req;
              irq_st_r <= CFR_IDLE;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end else if (!any_req) begin
            irq_st_r <= CFR_IDLE;
          end else if (retrig_kick) begin
            host_irq_n_o <= 1'b0;
            cnt_r <= 8'(HOLD_CYC - 1);
            irq_st_r <= CFR_PULSE;
          end
        end
        default: begin
          irq_st_r <= CFR_IDLE;
          host_irq_n_o <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      status_change_n_o <= 1'b1;
      speaker_out_n_o <= 1'b1;
    end else if (ce_i) begin
      status_change_n_o <= !(io_mode_i &&
        |(changed & gate_r));
      speaker_out_n_o <= !(speaker_in_i &&
        |(audio_r & {func_i[1].configured, func_i[0].configured}));
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i && bus_i.rd) begin
      rdata_o <= 8'h00;
      for (int f = 0; f < 2; f++) begin
        if (bus_i.addr == off(f, `CFR_F0_STAT, `CFR_F1_STAT)) begin
          rdata_o <= {changed[f], gate_r[f], eight_r[f], 1'b0,
                      audio_r[f], pdown_r[f], intr_live[f], retrig_r};
        end
        if (bus_i.addr == off(f, `CFR_F0_PIN, `CFR_F1_PIN)) begin
          rdata_o <= {2'b00, rdychg_r[f], 3'b000, ready_q_r[f], 1'b0};
        end
        if (bus_i.addr == off(f, `CFR_F0_RING, `CFR_F1_RING)) begin
          rdata_o <= {3'b000, ring_evt_r[f], 3'b000, ring_en_r[f]};
        end
        if (bus_i.addr == off(f, `CFR_F0_BASE_LO, `CFR_F1_BASE_LO)) begin
          rdata_o <= base_r[f][7:0];
        end
        if (bus_i.addr == off(f, `CFR_F0_BASE_HI, `CFR_F1_BASE_HI)) begin
          rdata_o <= {3'b000, base_r[f][12:8]};
        end
        if (bus_i.addr == off(f, `CFR_F0_MASK, `CFR_F1_MASK)) begin
          rdata_o <= mask_r[f];
        end
      end
    end
  end

  property p_pulse_len;
    @(posedge mclk_i) disable iff (!rst_n_i)
    $fell(host_irq_n_o) && !level_irq_select_i && ce_i ##1 ce_i[*8]
    |-> !host_irq_n_o;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse low shorter than expected");

  property p_stschg;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && !io_mode_i |=> status_change_n_o;
  endproperty
  a_stschg: assert property (p_stschg)
    else $error("status change outside io mode");

  property p_gate;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && ((changed & gate_r) == 2'b00) |=> status_change_n_o;
  endproperty
  a_gate: assert property (p_gate)
    else $error("status change without gated change");

  property p_pwr;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && pdown_r[0] |=> !function_power_ctl_o[0] && function_oe_n_o[0];
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("powered-down function still driven");

  property p_spk;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && audio_r == 2'b00 |=> speaker_out_n_o;
  endproperty
  a_spk: assert property (p_spk)
    else $error("speaker active with audio off");

  // a pin toggle must leave the flag set, even against a clear
  property p_rdy;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && (func_i[0].ready != ready_q_r[0]) |=> rdychg_r[0];
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready change missed");

  property p_ring;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && !func_i[0].ring_n && ring_en_r[0] |=> ring_evt_r[0];
  endproperty
  a_ring: assert property (p_ring)
    else $error("ring event not latched");

  property p_lvl;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && irq_st_r == CFR_IDLE && level_irq_select_i && !any_req
    |=> host_irq_n_o;
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("level irq asserted without request");

  property p_sel;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i && pdown_r[1] |=> !func_select_o[1];
  endproperty
  a_sel: assert property (p_sel)
    else $error("powered-down function selected");

  c_pulse: cover property (@(posedge mclk_i) $fell(host_irq_n_o));
  c_retrig: cover property (@(posedge mclk_i) retrig_kick && any_req);
  c_ring: cover property (@(posedge mclk_i) $rose(ring_evt_r[1]));
  c_lvl_gap: cover property (@(posedge mclk_i)
    irq_st_r == CFR_GAP && level_irq_select_i);
endmodule

// ### test/cfr_host_model.sv
// host socket model: byte-wide attribute accesses to the register bank
module cfr_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output cfr_pkg::cfr_bus_s bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfr_pkg::*;
  initial bus_o = '0;
  // 8-bit host: every register reached as a lone byte
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    bus_o = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge mclk_i);
    // released lines must not keep showing the old value
    bus_o = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    bus_o = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge mclk_i);
    bus_o = '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    d = rdata_i;
  endtask
endmodule

// ### test/cfr_regs_tb.sv
// self-checking bench for the card function register bank
`include "cfr_cfg.svh"
module cfr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cfr_pkg::*;
  localparam int LOWC = (`CFR_PULSE_CYC > `CFR_LOW_CYC) ?
    `CFR_PULSE_CYC : `CFR_LOW_CYC;
  logic mclk, rst_n, ce, io_mode, lvl_sel, spk, stc_n, irq_n, spk_n;
  logic [12:0] io_addr;
  cfr_func_s [1:0] fn;
  cfr_bus_s bus;
  logic [7:0] rdata;
  logic [1:0] pwr, oe_n, sel;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  cfr_regs u_cfr_regs (.mclk_i(mclk), .rst_n_i(rst_n), .ce_i(ce),
    .bus_i(bus), .io_mode_i(io_mode), .level_irq_select_i(lvl_sel),
    .func_i(fn), .speaker_in_i(spk), .io_addr_i(io_addr),
    .rdata_o(rdata), .status_change_n_o(stc_n), .host_irq_n_o(irq_n),
    .speaker_out_n_o(spk_n), .function_power_ctl_o(pwr),
    .function_oe_n_o(oe_n), .func_select_o(sel));
  cfr_host_model u_cfr_host_model (.mclk_i(mclk), .rdata_i(rdata),
    .bus_o(bus));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // extra cycle so registered effects have landed
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    u_cfr_host_model.wr(a, d);
    idle(1);
  endtask
  task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_cfr_host_model.rd(a, v);
    chk(v, e);
  endtask
  // waits for irq line at lvl, then counts cycles it stays there
  task automatic width(input logic lvl, output int k);
    int i;
    i = 0;
    k = 0;
    while (irq_n !== lvl && i < 40) begin
      i++;
      @(negedge mclk);
    end
    if (irq_n !== lvl) begin
      fail_count++;
      complete_run();
    end
    while (irq_n === lvl && k < 400) begin
      k++;
      @(negedge mclk);
    end
  endtask
  task automatic win(input bit f, input logic [12:0] b,
    input logic [7:0] m, input logic [12:0] a, input logic e);
    wr(f ? `CFR_F1_BASE_LO : `CFR_F0_BASE_LO, b[7:0]);
    wr(f ? `CFR_F1_BASE_HI : `CFR_F0_BASE_HI, {3'b000, b[12:8]});
    wr(f ? `CFR_F1_MASK : `CFR_F0_MASK, m);
    io_addr = a;
    idle(2);
    chk(sel[f], e);
  endtask
  task automatic t_reset();
    chk({irq_n, stc_n, pwr, oe_n}, 6'h3C);
    rdchk(`CFR_F0_PIN, 8'h00);
    rdchk(`CFR_F1_RING, 8'h00);
    rdchk(13'h1030, 8'h00);
    $display("reset done");
  endtask
  task automatic t_power();
    wr(`CFR_F0_STAT, 8'h04);
    chk({pwr, oe_n}, 4'h9);
    wr(`CFR_F0_STAT, 8'h00);
    chk({pwr, oe_n}, 4'hC);
    $display("power done");
  endtask
  task automatic t_ready();
    fn[0].ready = 1'b1;
    idle(3);
    rdchk(`CFR_F0_PIN, 8'h22);
    rdchk(`CFR_F0_STAT, 8'h80);
    chk(stc_n, 1'b1);
    wr(`CFR_F0_STAT, 8'h40);
    idle(1);
    chk(stc_n, 1'b0);
    // outside io mode the gated change must not reach the pin
    io_mode = 1'b0;
    idle(2);
    chk(stc_n, 1'b1);
    io_mode = 1'b1;
    idle(2);
    chk(stc_n, 1'b0);
    wr(`CFR_F0_PIN, 8'h22);
    rdchk(`CFR_F0_PIN, 8'h22);
    wr(`CFR_F0_PIN, 8'h02);
    rdchk(`CFR_F0_PIN, 8'h02);
    idle(1);
    chk(stc_n, 1'b1);
    $display("ready done");
  endtask
  task automatic t_ring();
    repeat (2) begin
      fn[1].ring_n = 1'b0;
      idle(1);
      fn[1].ring_n = 1'b1;
      idle(2);
      rdchk(`CFR_F1_RING, 8'h00);
      wr(`CFR_F1_RING, 8'h01);
      fn[1].ring_n = 1'b0;
      idle(1);
      fn[1].ring_n = 1'b1;
      idle(2);
      rdchk(`CFR_F1_RING, 8'h11);
      rdchk(`CFR_F1_STAT, 8'h80);
      wr(`CFR_F1_RING, 8'h11);
      rdchk(`CFR_F1_RING, 8'h11);
      wr(`CFR_F1_RING, 8'h10);
    end
    $display("ring done");
  endtask
  task automatic t_spk();
    wr(`CFR_F1_STAT, 8'h08);
    spk = 1'b1;
    idle(2);
    chk(spk_n, 1'b0);
    spk = 1'b0;
    idle(2);
    chk(spk_n, 1'b1);
    spk = 1'b1;
    fn[1].configured = 1'b0;
    idle(2);
    chk(spk_n, 1'b1);
    fn[1].configured = 1'b1;
    wr(`CFR_F1_STAT, 8'h00);
    $display("speaker done");
  endtask
  task automatic t_win();
    win(0, 13'h0374, 8'h07, 13'h0370, 1'b1);
    win(0, 13'h0374, 8'h07, 13'h0378, 1'b0);
    win(0, 13'h03F8, 8'h07, 13'h03FF, 1'b1);
    win(1, 13'h1FF0, 8'h0F, 13'h1FFF, 1'b1);
    win(1, 13'h1FF0, 8'h00, 13'h1FF1, 1'b0);
    win(1, 13'h1FF0, 8'hFF, 13'h1E00, 1'b0);
    $display("window done");
  endtask
  task automatic t_irq();
    fn[0].irq = 1'b1;
    idle(3);
    chk(irq_n, 1'b1);
    rdchk(`CFR_F0_STAT, 8'h42);
    fn[0].irq_enable = 1'b1;
    width(1'b0, n);
    chk(n, LOWC);
    wr(`CFR_F0_STAT, 8'h40);
    rdchk(`CFR_F0_STAT, 8'h42);
    chk(irq_n, 1'b1);
    wr(`CFR_F0_STAT, 8'h43);
    rdchk(`CFR_F1_STAT, 8'h01);
    fork
      wr(`CFR_F1_STAT, 8'h01);
      width(1'b0, n);
    join
    chk(n, LOWC);
    fn[0].irq = 1'b0;
    idle(3);
    rdchk(`CFR_F0_STAT, 8'h41);
    $display("pulse done");
  endtask
  task automatic t_level();
    lvl_sel = 1'b1;
    fn[1].irq_enable = 1'b1;
    fn[1].irq = 1'b1;
    idle(3);
    chk(irq_n, 1'b0);
    fork
      wr(`CFR_F0_STAT, 8'h41);
      width(1'b1, n);
    join
    chk(n, LOWC);
    chk(irq_n, 1'b0);
    fn[1].irq = 1'b0;
    idle(3);
    chk(irq_n, 1'b1);
    $display("level done");
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    io_mode = 1'b1;
    lvl_sel = 1'b0;
    spk = 1'b0;
    io_addr = '0;
    fn = '0;
    fn[0].configured = 1'b1;
    fn[1].configured = 1'b1;
    fn[0].ring_n = 1'b1;
    fn[1].ring_n = 1'b1;
    idle(20);
    rst_n = 1'b1;
    idle(2);
    t_reset();
    t_power();
    t_ready();
    t_ring();
    t_spk();
    t_win();
    t_irq();
    t_level();
    complete_run();
  end
endmodule
